// *** see_i2c_master.sv ***
// see_i2c_master: behavioural two-wire bus master for the memory slave
// assumes a pull-up on sda in the bench; lines change just after clock edges
`timescale 1ns/1ps
`default_nettype none
module see_i2c_master (
  // clock and sampled line
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  // driven lines
  output var  logic scl_o,
  output var  logic sda_low_o
);
  localparam int QTR = 31; // quarter bit, 2480 ns per bit
  logic glitch_en = 1'b0;
  // idle bus: clock high, data released
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  // set both lines, hold them a quarter bit
  task automatic step(input logic c, input logic l);
    scl_o     <= c;
    sda_low_o <= l;
    repeat (QTR) @(posedge ref_clk_i);
  endtask : step
  // start or repeated start: data falls while clock high
  task automatic start;
    step(scl_o, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask : start
  // stop: data rises while clock high, then bus free time
  task automatic stop;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
  endtask : stop
  // one bit: set with clock low, sampled mid high phase
  task automatic xfer_bit(input logic b, output logic r);
    step(1'b0, !b);
    step(1'b1, !b);
    r = sda_i;
    step(1'b1, !b);
    step(1'b0, !b);
    if (glitch_en) begin
      scl_o <= 1'b1; // 80 ns spike on scl
      repeat (4) @(posedge ref_clk_i);
      scl_o <= 1'b0;
      @(posedge ref_clk_i);
    end
  endtask : xfer_bit
  // eight bits msb first, then the acknowledge bit
  task automatic xfer_byte(input logic [7:0] d, input logic ack_bit,
                           output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
      q[i] = r;
    end
    xfer_bit(ack_bit, r);
    ack = !r;
  endtask : xfer_byte
endmodule : see_i2c_master
`default_nettype wire

// *** see_mem.sv ***
// see_mem: storage array with one write port and a registered read port
// assumes writes come from the commit engine and reads from the read pointer
`timescale 1ns/1ps
`default_nettype none
module see_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_reg [2**AW];

  // array write, no reset on storage
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // registered read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end

endmodule : see_mem
`default_nettype wire

// *** see_pkg.sv ***
// see_pkg: constants and carrier types for the two-wire serial memory slave
// assumes a single 50 MHz system clock; the serial clock is sampled, not used as a clock
package see_pkg;

  // system clock rate
  localparam int CLK_MHZ     = 50;

  // page organisation
  localparam int PAGE_BYTES  = 16;
  localparam int OFS_W       = 4;
  localparam int PAGE_AW_MIN = 3;
  localparam int PAGE_AW_MAX = 7;
  localparam int BYTE_W      = 8;
  localparam int SEL_W       = 3;
  localparam int BIT_CNT_W   = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;

  // serial clock limits in kHz, master side obligation
  localparam int SCL_STD_KHZ = 100;
  localparam int SCL_FST_KHZ = 400;

  // glitch rejection: pulses up to this width are ignored
  localparam int GLITCH_NS   = 100;
  localparam int FILT_CYC    = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W      = 3;
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC);

  // power-up ready delay and internal program time
  localparam int POWER_UP_READY_DELAY_US  = 1000;
  localparam int INTERNAL_PROGRAM_TIME_US = 5000;
  localparam int PU_CYC      = POWER_UP_READY_DELAY_US * CLK_MHZ;
  localparam int PROG_CYC    = INTERNAL_PROGRAM_TIME_US * CLK_MHZ;
  localparam int TMR_W       = 20;

  // fixed device type code in the slave address
  localparam logic [3:0] DEV_TYPE = 4'hA;

  // slave address byte as it arrives, msb first
  typedef struct packed {
    logic [3:0]       dev_type;
    logic [SEL_W-1:0] sel;
    logic             rd;
  } see_slave_addr_t;

  // filtered bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } see_bus_t;

  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_RACK
  } see_state_t;

endpackage : see_pkg

// *** see_slave.sv ***
// see_slave: two-wire serial memory slave with page buffer and program cycle
// assumes scl and sda come from pins, sampled by the 50 MHz system clock
// Contract
// (RULE1) storage is 16-byte pages, 8 to 128 pages by density
// (RULE2) works up to 100 kHz and 400 kHz serial clock; master keeps the rate
// (RULE3) writes buffer 1 to 16 bytes, committed in one program cycle
// (RULE4) reads shift bytes out, pointer advancing after each byte
// (RULE5) select pins compared with address so several parts share a bus
// (RULE6) commands ignored for up to 1 ms after power-up
// (RULE7) pulses of 100 ns or less on scl and sda are rejected
// (RULE8) answer only type 1010, select bits match or carry high address, lsb is read
// (RULE9) write increments low four address bits only, wrapping within the page
// (RULE10) no acknowledge of slave address while program cycle runs
// (RULE11) write protect sampled before first data byte; if high, nack and discard
// (RULE12) program cycle ends within write cycle time, then address is acked again
`timescale 1ns/1ps
`default_nettype none
module see_slave #(
  parameter int PAGE_AW  = 3,
  parameter int PU_CYC   = see_pkg::PU_CYC,
  parameter int PROG_CYC = see_pkg::PROG_CYC
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // serial bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n_o,
  // straps and protection
  input  wire logic device_select_pin_0_i,
  input  wire logic device_select_pin_1_i,
  input  wire logic device_select_pin_2_i,
  input  wire logic wp_i,
  // status
  output logic      ready_o,
  output logic      busy_o
);

  localparam int AW = PAGE_AW + see_pkg::OFS_W;                // [RULE1]
  localparam int HB = (AW > see_pkg::BYTE_W) ? AW - see_pkg::BYTE_W : 0;
  localparam logic [see_pkg::SEL_W-1:0] SEL_MASK = see_pkg::SEL_W'(3'h7 << HB);

  // join select field and address byte into a pointer
  function automatic logic [AW-1:0] see_join(input logic [see_pkg::SEL_W-1:0] sel,
                                             input logic [see_pkg::BYTE_W-1:0] lo);
    logic [see_pkg::SEL_W+see_pkg::BYTE_W-1:0] full;
    full = {sel, lo};
    return full[AW-1:0];
  endfunction : see_join

  // synchronisers
  logic [1:0] scl_s_reg, sda_s_reg, wp_s_reg;
  logic [see_pkg::SEL_W-1:0] pin_s1_reg, pin_s2_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s_reg  <= 2'h3;
      sda_s_reg  <= 2'h3;
      wp_s_reg   <= 2'h0;
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      scl_s_reg  <= {scl_s_reg[0], scl_i};
      sda_s_reg  <= {sda_s_reg[0], sda_i};
      wp_s_reg   <= {wp_s_reg[0], wp_i};
      pin_s1_reg <= {device_select_pin_2_i, device_select_pin_1_i, device_select_pin_0_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // glitch filters: a new level must persist past the glitch width
  see_pkg::see_bus_t raw, filt_reg, prev_reg;
  logic [see_pkg::FILT_W-1:0] fcnt_reg [2];
  assign raw = '{scl: scl_s_reg[1], sda: sda_s_reg[1]};
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_reg <= 2'h3;
      prev_reg <= 2'h3;
      fcnt_reg <= '{default: '0};
    end else begin
      prev_reg <= filt_reg;
      for (int i = 0; i < 2; i++) begin
        if (raw[i] == filt_reg[i]) begin
          fcnt_reg[i] <= '0;
        end else if (fcnt_reg[i] == see_pkg::FILT_LAST) begin
          filt_reg[i] <= raw[i];                               // [RULE7]
          fcnt_reg[i] <= '0;
        end else begin
          fcnt_reg[i] <= fcnt_reg[i] + 3'h1;
        end
      end
    end
  end

  // bus events
  wire scl_rise = filt_reg.scl & ~prev_reg.scl;                 // [RULE2]
  wire scl_fall = ~filt_reg.scl & prev_reg.scl;
  wire bus_start = prev_reg.scl & filt_reg.scl & prev_reg.sda & ~filt_reg.sda;
  wire bus_stop  = prev_reg.scl & filt_reg.scl & ~prev_reg.sda & filt_reg.sda;

  // protocol state
  see_pkg::see_state_t state_reg;
  logic [see_pkg::BIT_CNT_W-1:0] bcnt_reg;
  logic [see_pkg::BYTE_W-1:0]    rx_reg, tx_reg;
  logic [AW-1:0]                 ptr_reg;
  logic                          ack_reg, mack_reg, wp_lat_reg;
  logic [see_pkg::PAGE_BYTES-1:0] vmask_reg;
  logic [see_pkg::BYTE_W-1:0]    pbuf_reg [see_pkg::PAGE_BYTES];
  logic [see_pkg::TMR_W-1:0]     pu_reg, prog_reg;
  logic [see_pkg::OFS_W:0]       cidx_reg;
  logic [see_pkg::BYTE_W-1:0]    rdata;

  // decode of the received slave address
  see_pkg::see_slave_addr_t sa;
  assign sa = rx_reg;
  wire byte_done = (bcnt_reg == see_pkg::BITS_PER_BYTE);
  wire sel_ok    = ((sa.sel ^ pin_s2_reg) & SEL_MASK) == 3'h0;        // [RULE5]
  wire dev_match = (sa.dev_type == see_pkg::DEV_TYPE) && sel_ok      // [RULE8]
                   && ready_o && !busy_o;                            // [RULE6] [RULE10]
  wire [see_pkg::OFS_W-1:0] ofs = ptr_reg[see_pkg::OFS_W-1:0];
  wire [see_pkg::SEL_W-1:0] ptr_hi = see_pkg::SEL_W'(ptr_reg >> see_pkg::BYTE_W); // bits above byte

  // commit engine: buffered bytes go to the array at the start of the cycle
  wire commit_we = busy_o && !cidx_reg[see_pkg::OFS_W]
                   && vmask_reg[cidx_reg[see_pkg::OFS_W-1:0]];                    // [RULE3]
  wire [AW-1:0] commit_addr = {ptr_reg[AW-1:see_pkg::OFS_W], cidx_reg[see_pkg::OFS_W-1:0]};
  wire prog_go = bus_stop && (state_reg == see_pkg::ST_WDATA) && (vmask_reg != '0)
                 && !wp_lat_reg && !busy_o;

  see_mem #(.AW(AW), .DW(see_pkg::BYTE_W)) u_mem (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .we_i      (commit_we),
    .waddr_i   (commit_addr),
    .wdata_i   (pbuf_reg[cidx_reg[see_pkg::OFS_W-1:0]]),
    .raddr_i   (ptr_reg),
    .rdata_o   (rdata)
  );

  // power-up delay and program timer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu_reg   <= '0;
      ready_o  <= 1'b0;
      prog_reg <= '0;
      busy_o   <= 1'b0;
      cidx_reg <= '0;
    end else begin
      if (!ready_o) begin
        pu_reg  <= pu_reg + 20'h1;
        ready_o <= (pu_reg == see_pkg::TMR_W'(PU_CYC - 1));            // [RULE6]
      end
      if (prog_go) begin
        busy_o   <= 1'b1;
        prog_reg <= '0;
        cidx_reg <= '0;
      end else if (busy_o) begin
        prog_reg <= prog_reg + 20'h1;
        if (!cidx_reg[see_pkg::OFS_W]) begin
          cidx_reg <= cidx_reg + 5'h1;
        end
        if (prog_reg == see_pkg::TMR_W'(PROG_CYC - 1)) begin
          busy_o <= 1'b0;                                            // [RULE12]
        end
      end
    end
  end

  // serial protocol engine
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg  <= see_pkg::ST_IDLE;
      bcnt_reg   <= '0;
      rx_reg     <= '0;
      tx_reg     <= '0;
      ptr_reg    <= '0;
      ack_reg    <= 1'b0;
      mack_reg   <= 1'b0;
      wp_lat_reg <= 1'b0;
      vmask_reg  <= '0;
      pbuf_reg   <= '{default: '0};
      sda_o      <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else if (busy_o && !prog_go) begin
      // buffer held until program cycle ends; bus ignored meanwhile
      sda_oe_n_o <= 1'b1;
      state_reg  <= see_pkg::ST_IDLE;
      if (prog_reg == see_pkg::TMR_W'(PROG_CYC - 1)) begin
        vmask_reg <= '0;
      end
    end else if (bus_start) begin
      state_reg  <= see_pkg::ST_DEV;
      bcnt_reg   <= '0;
      ack_reg    <= 1'b0;
      sda_oe_n_o <= 1'b1;
      vmask_reg  <= '0;                                              // repeated start drops a write
    end else if (bus_stop) begin
      state_reg  <= see_pkg::ST_IDLE;
      sda_oe_n_o <= 1'b1;
      if (!prog_go) begin
        vmask_reg <= '0;
      end
    end else if (scl_rise) begin
      if (state_reg == see_pkg::ST_RACK) begin
        mack_reg <= ~filt_reg.sda;
      end else if (state_reg != see_pkg::ST_IDLE && !ack_reg) begin
        rx_reg   <= {rx_reg[6:0], filt_reg.sda};
        bcnt_reg <= bcnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      case (state_reg)
        see_pkg::ST_IDLE: begin
          sda_oe_n_o <= 1'b1;
        end
        see_pkg::ST_RDATA: begin
          if (ack_reg) begin
            // end of address acknowledge: first byte goes out
            ack_reg    <= 1'b0;
            sda_oe_n_o <= rdata[7];                                  // [RULE4]
            tx_reg     <= {rdata[6:0], 1'b0};
            ptr_reg    <= ptr_reg + 1'b1;
            bcnt_reg   <= '0;
          end else if (byte_done) begin
            sda_oe_n_o <= 1'b1;                                      // master ack slot
            state_reg  <= see_pkg::ST_RACK;
          end else begin
            sda_oe_n_o <= tx_reg[7];
            tx_reg     <= {tx_reg[6:0], 1'b0};
          end
        end
        see_pkg::ST_RACK: begin
          if (mack_reg) begin
            sda_oe_n_o <= rdata[7];                                  // [RULE4]
            tx_reg     <= {rdata[6:0], 1'b0};
            ptr_reg    <= ptr_reg + 1'b1;
            bcnt_reg   <= '0;
            state_reg  <= see_pkg::ST_RDATA;
          end else begin
            state_reg  <= see_pkg::ST_IDLE;
          end
        end
        default: begin
          if (ack_reg) begin
            // end of our acknowledge bit
            ack_reg    <= 1'b0;
            bcnt_reg   <= '0;
            sda_oe_n_o <= 1'b1;
            if (state_reg == see_pkg::ST_WDATA && vmask_reg == '0) begin
              wp_lat_reg <= wp_s_reg[1];                             // [RULE11]
            end
          end else if (byte_done) begin
            case (state_reg)
              see_pkg::ST_DEV: begin
                if (dev_match) begin
                  ack_reg    <= 1'b1;
                  sda_oe_n_o <= 1'b0;
                  state_reg  <= sa.rd ? see_pkg::ST_RDATA : see_pkg::ST_WADDR;
                  if (sa.rd) begin
                    ptr_reg <= see_join(sa.sel, see_pkg::BYTE_W'(ptr_reg));
                  end else begin
                    ptr_reg <= see_join(sa.sel, see_pkg::BYTE_W'(0));
                  end
                end else begin
                  state_reg <= see_pkg::ST_IDLE;                     // [RULE10]
                end
              end
              see_pkg::ST_WADDR: begin
                ptr_reg    <= see_join(ptr_hi, rx_reg);
                ack_reg    <= 1'b1;
                sda_oe_n_o <= 1'b0;
                state_reg  <= see_pkg::ST_WDATA;
              end
              see_pkg::ST_WDATA: begin
                if (wp_lat_reg) begin
                  state_reg <= see_pkg::ST_IDLE;                     // [RULE11]
                  vmask_reg <= '0;
                end else begin
                  pbuf_reg[ofs]  <= rx_reg;                          // [RULE3]
                  vmask_reg[ofs] <= 1'b1;
                  ptr_reg[see_pkg::OFS_W-1:0] <= ofs + 4'h1;         // [RULE9]
                  ack_reg    <= 1'b1;
                  sda_oe_n_o <= 1'b0;
                end
              end
              default: begin
                state_reg <= see_pkg::ST_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule : see_slave
`default_nettype wire

// *** see_slave_bench.sv ***
// see_slave_bench: self-checking bench for the serial memory slave
// assumes see_slave, see_slave_properties and see_i2c_master compiled first
`timescale 1ns/1ps
`default_nettype none
module see_slave_bench;
  logic       ref_clk_i;
  logic       rst_n_i;
  logic [2:0] sel;
  logic       wp;
  logic       scl;
  logic       m_low;
  logic       sda_o;
  logic       sda_oe_n;
  logic       ready;
  logic       busy;
  wire  logic sda_line;
  int         errors;
  int         check_count;
  logic [7:0] mem_exp [128];
  logic [7:0] q;
  logic [7:0] d;
  logic       ack;
  logic [2:0] pg;
  // open-drain data line with pull-up
  assign sda_line = m_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);
  see_slave #(.PAGE_AW(3), .PU_CYC(1500), .PROG_CYC(3000)) DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .device_select_pin_0_i(sel[0]),
    .device_select_pin_1_i(sel[1]), .device_select_pin_2_i(sel[2]), .wp_i(wp),
    .ready_o(ready), .busy_o(busy));
  see_i2c_master MST (.ref_clk_i(ref_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));
  // 50 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // optional start, one written byte, acknowledge compared
  task automatic put(input logic st, input logic [7:0] b, input logic ea, input string what);
    if (st) begin
      MST.start();
    end
    MST.xfer_byte(b, 1'b1, q, ack);
    chk(what, {7'h00, ea}, {7'h00, ack});
  endtask : put
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // hang guard, about 1.6x the expected run
  initial begin
    repeat (95000) @(posedge ref_clk_i);
    errors++;
    $display("MISMATCH watchdog expected finish seen hang");
    summarize();
  end
  initial begin
    rst_n_i     = 1'b0;
    wp          = 1'b0;
    sel         = 3'h0;
    errors      = 0;
    check_count = 0;
    void'($urandom(32'h0C50));
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    sel     <= 3'($urandom);
    pg      = 3'($urandom);
    @(posedge ref_clk_i);
    chk("ready", 8'h00, {7'h00, ready});
    put(1'b1, {4'hA, sel, 1'b0}, 1'b0, "early addr");
    MST.stop();
    for (int i = 0; i < 4000 && ready !== 1'b1; i++) @(posedge ref_clk_i);
    chk("ready", 8'h01, {7'h00, ready});
    // each select bit flipped, then wrong type code
    for (int k = 0; k < 4; k++) begin
      put(1'b1, k == 3 ? {4'hB, sel, 1'b0} : {4'hA, sel ^ (3'h1 << k), 1'b0}, 1'b0, "bad addr");
      MST.stop();
    end
    // 18 bytes from offset 13 wrap inside the page, under scl spikes
    MST.glitch_en = 1'b1;
    put(1'b1, {4'hA, sel, 1'b0}, 1'b1, "wr addr");
    put(1'b0, {1'b0, pg, 4'hD}, 1'b1, "word addr");
    for (int n = 0; n < 18; n++) begin
      d = 8'($urandom);
      mem_exp[{pg, 4'(13 + n)}] = d;
      put(1'b0, d, 1'b1, "data");
    end
    MST.stop();
    MST.glitch_en = 1'b0;
    chk("busy", 8'h01, {7'h00, busy});
    put(1'b1, {4'hA, sel, 1'b0}, 1'b0, "busy poll");
    for (int i = 0; i < 8 && ack !== 1'b1; i++) begin
      MST.stop();
      MST.start();
      MST.xfer_byte({4'hA, sel, 1'b0}, 1'b1, q, ack);
    end
    chk("poll", 8'h01, {7'h00, ack});
    // protected write: first data byte refused, nothing programmed
    wp <= 1'b1;
    put(1'b0, {1'b0, pg, 4'h0}, 1'b1, "word addr");
    put(1'b0, ~mem_exp[{pg, 4'h0}], 1'b0, "wp data");
    MST.stop();
    repeat (20) @(posedge ref_clk_i);
    chk("wp busy", 8'h00, {7'h00, busy});
    wp <= 1'b0;
    // sequential read of the whole page
    put(1'b1, {4'hA, sel, 1'b0}, 1'b1, "wr addr");
    put(1'b0, {1'b0, pg, 4'h0}, 1'b1, "word addr");
    put(1'b1, {4'hA, sel, 1'b1}, 1'b1, "rd addr");
    for (int n = 0; n < 16; n++) begin
      MST.xfer_byte(8'hFF, n == 15, q, ack);
      chk("read", mem_exp[{pg, 4'(n)}], q);
    end
    MST.stop();
    summarize();
  end
endmodule : see_slave_bench
bind see_slave see_slave_properties #(.PU_CYC(PU_CYC), .PROG_CYC(PROG_CYC)) u_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i), .ready_o(ready_o), .busy_o(busy_o));
`default_nettype wire

// *** see_slave_properties.sv ***
// see_slave_properties: port timing checks for the serial memory slave
// assumes it is bound into see_slave; one clock domain, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module see_slave_properties #(
  parameter int PU_CYC   = 1500,
  parameter int PROG_CYC = 3000
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // bus, protection and status
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_n_o,
  input wire logic wp_i,
  input wire logic ready_o,
  input wire logic busy_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [19:0] pu_cnt_reg;
  logic [19:0] bsy_cnt_reg;
  // cycles since reset release, cycles of the running program cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu_cnt_reg  <= '0;
      bsy_cnt_reg <= '0;
    end else begin
      pu_cnt_reg  <= pu_cnt_reg + 20'(pu_cnt_reg != 20'hFFFFF);
      bsy_cnt_reg <= busy_o ? bsy_cnt_reg + 20'h00001 : 20'h00000;
    end
  end
  property p_silent_early; !ready_o |-> sda_oe_n_o; endproperty
  a_silent_early: assert property (p_silent_early) else $error("drive before ready");
  property p_ready_early; (pu_cnt_reg < PU_CYC - 3) |-> !ready_o; endproperty
  a_ready_early: assert property (p_ready_early) else $error("ready too early");
  property p_ready_late; (pu_cnt_reg > PU_CYC + 3) |-> ready_o; endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too late");
  property p_quiet_busy; busy_o |-> sda_oe_n_o; endproperty
  a_quiet_busy: assert property (p_quiet_busy) else $error("drive while busy");
  property p_prog_short; $fell(busy_o) |-> bsy_cnt_reg >= PROG_CYC - 3; endproperty
  a_prog_short: assert property (p_prog_short) else $error("program cycle short");
  property p_prog_long; bsy_cnt_reg <= PROG_CYC + 3; endproperty
  a_prog_long: assert property (p_prog_long) else $error("program cycle long");
  property p_stable_high; $changed(sda_oe_n_o) |-> !scl_i; endproperty
  a_stable_high: assert property (p_stable_high) else $error("sda moved, scl high");
  property p_drive_hold; $fell(sda_oe_n_o) |=> !sda_oe_n_o [*8]; endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("low bit too short");
  property p_prog_after_stop; $rose(busy_o) |-> scl_i && sda_i; endproperty
  a_prog_after_stop: assert property (p_prog_after_stop) else $error("busy not after stop");
  property p_wp_blocks; $rose(busy_o) |-> !$past(wp_i, 2); endproperty
  a_wp_blocks: assert property (p_wp_blocks) else $error("protected write run");
  // main scenarios reached
  c_prog: cover property ($rose(busy_o));
  c_drive: cover property ($fell(sda_oe_n_o));
  c_ready: cover property ($rose(ready_o));
endmodule : see_slave_properties
`default_nettype wire
